// ### verilog/crr_pkg.sv
/*
 * Shared constants and carrier types for the conversion result register
 * bank: register offsets, field positions, reset values and the struct
 * that carries one channel's finished conversion from the core.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
`default_nettype none

package crr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CRR_CHANNELS = 4;
    localparam int CRR_ADDR_W = 8;
    localparam int CRR_DATA_W = 16;
    localparam int CRR_RESULT_W = 28;
    localparam int CRR_FLAG_W = 4;
    localparam int CRR_HIGH_DATA_W = 12;
    localparam int CRR_REF_PER_COUNT = 16;
    localparam int CRR_INTERVAL_W = 20;
    localparam int CRR_CH_IDX_W = 2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CRR_CH0_RESULT_HIGH_FLAGS = 8'h00;
    localparam logic [7:0] CRR_CH0_RESULT_LOW = 8'h01;
    localparam logic [7:0] CRR_CH1_RESULT_HIGH_FLAGS = 8'h02;
    localparam logic [7:0] CRR_CH1_RESULT_LOW = 8'h03;
    localparam logic [7:0] CRR_CH2_RESULT_HIGH_FLAGS = 8'h04;
    localparam logic [7:0] CRR_CH2_RESULT_LOW = 8'h05;
    localparam logic [7:0] CRR_CH3_RESULT_HIGH_FLAGS = 8'h06;
    localparam logic [7:0] CRR_CH3_RESULT_LOW = 8'h07;
    localparam logic [7:0] CRR_CH0_CONVERSION_INTERVAL = 8'h08;
    // Result words sit in pairs below this offset: even high, odd low
    localparam logic [7:0] CRR_RESULT_SPAN = 8'h08;

    // ------------------------------------------------------------------
    // Field positions inside a high result word
    // ------------------------------------------------------------------
    localparam int CRR_UNDERRANGE_BIT = 15;
    localparam int CRR_OVERRANGE_BIT = 14;
    localparam int CRR_TIMEOUT_BIT = 13;
    localparam int CRR_AMPLITUDE_BIT = 12;
    localparam int CRR_HIGH_DATA_MSB = 11;
    localparam int CRR_RESULT_SPLIT = 16;

    // ------------------------------------------------------------------
    // Reset values and reserved range
    // ------------------------------------------------------------------
    localparam logic [15:0] CRR_RESULT_RESET = 16'h0000;
    localparam logic [15:0] CRR_INTERVAL_RESET = 16'h0080;
    localparam logic [15:0] CRR_INTERVAL_MIN = 16'h0005;
    localparam logic [15:0] CRR_UNMAPPED_DATA = 16'h0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic underrange;
        logic overrange;
        logic timeout;
        logic amplitude;
    } crr_flags_t;

    typedef struct packed {
        logic done;
        crr_flags_t err;
        logic [CRR_RESULT_W-1:0] result;
    } crr_conv_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [CRR_ADDR_W-1:0] addr;
        logic [CRR_DATA_W-1:0] wdata;
    } crr_req_t;

endpackage : crr_pkg

`default_nettype wire

// ### verilog/crr_interval_timer.sv
/*
 * Channel 0 conversion interval timer. Counts reference clock ticks and
 * pulses once per interval of max(count, 5) x 16 ticks.
 * Assumes ref_tick is a one-cycle pulse per reference period, synchronous
 * to core_clk, and that the count input changes only between intervals
 * or that a restart on change is acceptable.
 */
`timescale 1ns/100ps
`default_nettype none

module crr_interval_timer
    import crr_pkg::*;
(
    input wire logic core_clk, // Block clock
    input wire logic nrst, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic ref_tick, // One pulse per reference period
    input wire logic [15:0] count, // Interval in units of 16 ticks
    output logic interval_done // Pulse at end of each interval
);

    logic [15:0] count_eff;
    logic [CRR_INTERVAL_W-1:0] limit;
    logic [CRR_INTERVAL_W-1:0] ticks_q;
    logic [15:0] count_seen_q;

    // Reserved counts would give a uselessly short interval; hold at minimum
    assign count_eff = (count < CRR_INTERVAL_MIN) ? CRR_INTERVAL_MIN : count;
    assign limit = CRR_INTERVAL_W'({count_eff, 4'h0}) - CRR_INTERVAL_W'(1);

    // --------------------------------------------------------------------
    // Tick counter
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ticks_q <= '0;
            count_seen_q <= CRR_INTERVAL_RESET;
        end
        else if (clk_en)
        begin
            count_seen_q <= count_eff;
            if (count_eff != count_seen_q)
            begin
                // New setting starts a fresh interval
                ticks_q <= '0;
            end
            else if (ref_tick)
            begin
                if (ticks_q >= limit)
                begin
                    ticks_q <= '0;
                end
                else
                begin
                    ticks_q <= ticks_q + CRR_INTERVAL_W'(1);
                end
            end
        end
    end

    // --------------------------------------------------------------------
    // End-of-interval pulse
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            interval_done <= 1'b0;
        end
        else if (clk_en)
        begin
            interval_done <= ref_tick && (ticks_q >= limit)
                && (count_eff == count_seen_q);
        end
    end

endmodule : crr_interval_timer

`default_nettype wire

// ### verilog/crr_regs.sv
/*
 * Conversion result register bank: per-channel 28-bit results split in a
 * high word with four read-clearing error flags and a low word, shadow
 * stores for coherent readback, and the channel 0 interval setting.
 * Assumes the serial front end has already turned host transfers into
 * single-cycle read and write strobes with a register offset, and that
 * the conversion core reports each finished conversion as a pulse.
 */
`timescale 1ns/100ps
`default_nettype none

module crr_regs
    import crr_pkg::*;
#(
    parameter bit FOUR_CH = 1'b1 // Zero gives the two-channel variant
)
(
    input wire logic core_clk, // 10 MHz block clock
    input wire logic nrst, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire crr_req_t req, // Register read/write request
    input wire crr_conv_t conv [CRR_CHANNELS], // Finished conversions
    input wire logic ref_tick, // Channel 0 reference period pulse
    output logic [CRR_DATA_W-1:0] rd_data_q, // Read data
    output logic rd_valid_q, // Read data valid pulse
    output logic unmapped_q, // Last access hit no register
    output logic [15:0] ch0_conversion_interval_q, // Interval setting
    output logic ch0_interval_done // End of channel 0 interval
);

    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_result(input logic [CRR_ADDR_W-1:0] a);
        is_result = (a < CRR_RESULT_SPAN);
    endfunction : is_result

    function automatic logic is_high(input logic [CRR_ADDR_W-1:0] a);
        is_high = is_result(a) && !a[0];
    endfunction : is_high

    function automatic logic [CRR_CH_IDX_W-1:0] chan_of(
        input logic [CRR_ADDR_W-1:0] a
    );
        chan_of = a[CRR_CH_IDX_W:1];
    endfunction : chan_of

    function automatic logic chan_present(
        input logic [CRR_CH_IDX_W-1:0] c
    );
        chan_present = FOUR_CH || (c < CRR_CH_IDX_W'(2));
    endfunction : chan_present

    // ------------------------------------------------------------------
    // Per-channel state
    // ------------------------------------------------------------------
    logic [CRR_RESULT_W-1:0] shadow_q [CRR_CHANNELS];
    logic [CRR_DATA_W-1:0] low_q [CRR_CHANNELS];
    crr_flags_t flags_q [CRR_CHANNELS];
    logic [CRR_CHANNELS-1:0] high_rd;
    logic [CRR_DATA_W-1:0] high_word [CRR_CHANNELS];

    genvar ch;
    generate
        for (ch = 0; ch < CRR_CHANNELS; ch++)
        begin : g_chan
            logic present;
            crr_flags_t err_in;

            // Absent channels never record and always read zero
            assign present = chan_present(CRR_CH_IDX_W'(ch));
            assign high_rd[ch] = req.rd && is_high(req.addr)
                && (chan_of(req.addr) == CRR_CH_IDX_W'(ch));
            assign err_in = (conv[ch].done && present) ? conv[ch].err : '0;

            // Word as the host sees it on a high read: fresh shadow data
            // alongside the flags as they stood before the clear
            assign high_word[ch] = {
                flags_q[ch].underrange,
                flags_q[ch].overrange,
                flags_q[ch].timeout,
                flags_q[ch].amplitude,
                shadow_q[ch][CRR_RESULT_W-1:CRR_RESULT_SPLIT]
            };

            // ----------------------------------------------------------
            // Shadow store, loaded on every finished conversion
            // ----------------------------------------------------------
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    shadow_q[ch] <= '0;
                end
                else if (clk_en && conv[ch].done && present)
                begin
                    shadow_q[ch] <= conv[ch].result;
                end
            end

            // ----------------------------------------------------------
            // Low word, refreshed by a high read (which itself shows the
            // shadow) so that a later conversion cannot split the pair
            // ----------------------------------------------------------
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    low_q[ch] <= CRR_RESULT_RESET;
                end
                else if (clk_en && high_rd[ch] && present)
                begin
                    low_q[ch] <= shadow_q[ch][CRR_RESULT_SPLIT-1:0];
                end
            end

            // ----------------------------------------------------------
            // Sticky error flags; a conversion error in the same cycle as
            // the clearing read survives it
            // ----------------------------------------------------------
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    flags_q[ch] <= '0;
                end
                else if (clk_en)
                begin
                    if (high_rd[ch])
                    begin
                        flags_q[ch] <= err_in;
                    end
                    else
                    begin
                        flags_q[ch] <= flags_q[ch] | err_in;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Channel 0 interval setting
    // ------------------------------------------------------------------
    // Reserved values are stored as written; the timer holds the minimum
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ch0_conversion_interval_q <= CRR_INTERVAL_RESET;
        end
        else if (clk_en && req.wr
            && (req.addr == CRR_CH0_CONVERSION_INTERVAL))
        begin
            ch0_conversion_interval_q <= req.wdata;
        end
    end

    crr_interval_timer u_timer (
        .core_clk (core_clk),
        .nrst (nrst),
        .clk_en (clk_en),
        .ref_tick (ref_tick),
        .count (ch0_conversion_interval_q),
        .interval_done (ch0_interval_done)
    );

    // ------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------
    logic [CRR_DATA_W-1:0] rd_mux;
    logic mapped;

    always_comb
    begin
        rd_mux = CRR_UNMAPPED_DATA;
        mapped = 1'b1;
        if (is_result(req.addr))
        begin
            if (!chan_present(chan_of(req.addr)))
            begin
                mapped = 1'b0;
            end
            else if (is_high(req.addr))
            begin
                rd_mux = high_word[chan_of(req.addr)];
            end
            else
            begin
                // Low word only coherent after its high word was read
                rd_mux = low_q[chan_of(req.addr)];
            end
        end
        else if (req.addr == CRR_CH0_CONVERSION_INTERVAL)
        begin
            rd_mux = ch0_conversion_interval_q;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid_q <= req.rd;
            if (req.rd)
            begin
                rd_data_q <= rd_mux;
            end
        end
    end

    // Writes to read-only words are dropped but still count as mapped
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            unmapped_q <= 1'b0;
        end
        else if (clk_en && (req.rd || req.wr))
        begin
            unmapped_q <= !mapped;
        end
    end

endmodule : crr_regs

`default_nettype wire

// ### verification/crr_regs_monitor.sv
/*
 * Port checks for the conversion result register bank.
 * Assumes it is bound into crr_regs and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none

module crr_regs_monitor
    import crr_pkg::*;
#(
    parameter bit FOUR_CH = 1'b1 // Variant select
)
(
    input wire logic core_clk, // Block clock
    input wire logic nrst, // Async reset, active low
    input wire logic clk_en, // Clock enable
    input wire crr_req_t req, // Register request
    input wire crr_conv_t conv [CRR_CHANNELS], // Finished conversions
    input wire logic ref_tick, // Reference period pulse
    input wire logic [CRR_DATA_W-1:0] rd_data_q, // Read data
    input wire logic rd_valid_q, // Read valid pulse
    input wire logic unmapped_q, // Unmapped access
    input wire logic [15:0] ch0_conversion_interval_q, // Interval setting
    input wire logic ch0_interval_done // Interval end pulse
);
    logic [15:0] prev_q;
    logic [15:0] eff;
    logic [20:0] tick_q;
    logic [20:0] span;

    // Reserved settings run as the minimum, so 3 then 5 is no change
    assign eff = (ch0_conversion_interval_q < CRR_INTERVAL_MIN) ?
        CRR_INTERVAL_MIN : ch0_conversion_interval_q;
    assign span = 21'(eff) * 21'h10;

    // Ticks since the last interval end; a new setting restarts the count
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_q <= CRR_INTERVAL_RESET;
            tick_q <= '0;
        end
        else if (clk_en)
        begin
            prev_q <= eff;
            if (prev_q != eff)
                tick_q <= '0;
            else if (ch0_interval_done)
                tick_q <= 21'(ref_tick);
            else
                tick_q <= tick_q + 21'(ref_tick);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    AST_RD_ANSWER: assert property (req.rd && clk_en |=> rd_valid_q)
        else $error("read strobe not answered one cycle later");
    AST_RD_ONLY: assert property (
        rd_valid_q && $past(clk_en) |-> $past(req.rd))
        else $error("read valid without a read strobe");
    AST_WR_INTERVAL: assert property (
        req.wr && clk_en && req.addr == CRR_CH0_CONVERSION_INTERVAL
        |=> ch0_conversion_interval_q == $past(req.wdata))
        else $error("interval setting did not take written value");
    AST_RO_WORDS: assert property (
        req.wr && clk_en && req.addr < CRR_RESULT_SPAN
        && (FOUR_CH || req.addr < CRR_CH2_RESULT_HIGH_FLAGS)
        |=> $stable(ch0_conversion_interval_q) && $stable(rd_data_q)
        && !unmapped_q)
        else $error("result word write disturbed interval setting");
    AST_UNMAPPED: assert property (
        req.rd && clk_en && req.addr > CRR_CH0_CONVERSION_INTERVAL
        |=> rd_data_q == CRR_UNMAPPED_DATA && unmapped_q)
        else $error("unmapped read not zero or not flagged");
    AST_FLAGS_CLEAR: assert property (
        req.rd && req.addr == CRR_CH1_RESULT_HIGH_FLAGS && !conv[1].done
        ##1 req.rd && req.addr == CRR_CH1_RESULT_HIGH_FLAGS
        |=> rd_data_q[15:12] == 4'h0)
        else $error("error flags survived a high word read");
    AST_HIGH_REPEAT: assert property (
        req.rd && req.addr == CRR_CH1_RESULT_HIGH_FLAGS && !conv[1].done
        ##1 req.rd && req.addr == CRR_CH1_RESULT_HIGH_FLAGS
        |=> rd_data_q[11:0] == $past(rd_data_q[11:0]))
        else $error("high result bits changed without a conversion");
    AST_TIMER_DONE: assert property (
        ch0_interval_done |-> tick_q == span)
        else $error("interval ended at wrong tick count");
    AST_TIMER_BOUND: assert property (
        eff == prev_q |-> tick_q <= span)
        else $error("interval overran its tick count");
endmodule : crr_regs_monitor

bind crr_regs crr_regs_monitor #(.FOUR_CH(FOUR_CH)) u_monitor (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .req(req),
    .conv(conv),
    .ref_tick(ref_tick),
    .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q),
    .unmapped_q(unmapped_q),
    .ch0_conversion_interval_q(ch0_conversion_interval_q),
    .ch0_interval_done(ch0_interval_done)
);

`default_nettype wire

// ### verification/crr_host_model.sv
/*
 * Host side of the register port: single-cycle read and write strobes.
 * Assumes inputs change 1 ns after the rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

module crr_host_model
    import crr_pkg::*;
(
    input wire logic core_clk, // Block clock
    output var crr_req_t req, // Strobes to the bank
    input wire logic [CRR_DATA_W-1:0] rd_data_q // Read data
);
    initial req = '0;

    // Hold keeps the strobe up so the next read follows with no gap
    task automatic rd(input logic [7:0] a, input bit hold,
        output logic [15:0] d);
        if (req.rd !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
        end
        req.rd = 1'b1;
        req.addr = a;
        @(posedge core_clk);
        #1;
        d = rd_data_q;
        if (!hold)
            req.rd = 1'b0;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        #1;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = v;
        @(posedge core_clk);
        #1;
        req.wr = 1'b0;
    endtask : wr

    task automatic rd_result(input int ch, output logic [15:0] hi,
        output logic [15:0] lo);
        rd(8'(2 * ch), 1'b1, hi);
        rd(8'(2 * ch + 1), 1'b0, lo);
    endtask : rd_result
endmodule : crr_host_model

`default_nettype wire

// ### verification/test_conversion_result_regs.sv
/*
 * Self-checking bench for the result register bank.
 * Assumes a 10 MHz clock and the host model for register traffic.
 */
`timescale 1ns/100ps
`default_nettype none

module test_conversion_result_regs
    import crr_pkg::*;
;
    logic core_clk;
    logic nrst;
    logic clk_en;
    crr_req_t req;
    crr_conv_t conv [CRR_CHANNELS];
    logic ref_tick;
    logic [15:0] rd_data_q;
    logic rd_valid_q;
    logic unmapped_q;
    logic [15:0] ival;
    logic done;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [27:0] res;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    crr_regs #(.FOUR_CH(1'b1)) i_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .req(req),
        .conv(conv),
        .ref_tick(ref_tick),
        .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q),
        .unmapped_q(unmapped_q),
        .ch0_conversion_interval_q(ival),
        .ch0_interval_done(done)
    );

    crr_host_model i_host (
        .core_clk(core_clk),
        .req(req),
        .rd_data_q(rd_data_q)
    );

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    initial ref_tick = 1'b0;
    always @(posedge core_clk) ref_tick <= #1 ~ref_tick;

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic convert(input int ch, input logic [3:0] err,
        input logic [27:0] r);
        @(posedge core_clk);
        #1;
        conv[ch] = {1'b1, err, r};
        @(posedge core_clk);
        #1;
        conv[ch].done = 1'b0;
    endtask : convert

    task automatic wait_done(output int m);
        for (m = 0; m < 400 && done !== 1'b1; m++)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask : wait_done

    task automatic finish_test;
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial
    begin
        nrst = 1'b0;
        clk_en = 1'b1;
        for (int c = 0; c < CRR_CHANNELS; c++)
            conv[c] = '0;
        repeat (16) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        check(ival, CRR_INTERVAL_RESET);
        for (int a = 0; a < 9; a++)
        begin
            i_host.rd(8'(a), 1'b0, hi);
            check(hi, a == 8 ? 16'h0080 : 16'h0000);
        end
        // Each error bit alone, then a repeated high read with no gap
        for (int k = 0; k < 4; k++)
        begin
            res = 28'hA5C3E10 + 28'(k);
            convert(1, 4'h1 << k, res);
            i_host.rd_result(1, hi, lo);
            check(hi, {4'h1 << k, res[27:16]});
            check(lo, res[15:0]);
            i_host.rd(CRR_CH1_RESULT_HIGH_FLAGS, 1'b1, hi);
            i_host.rd(CRR_CH1_RESULT_HIGH_FLAGS, 1'b0, hi);
            check(hi, {4'h0, res[27:16]});
        end
        // Low word before high keeps the older copy
        convert(1, 4'h0, 28'h0123456);
        i_host.rd(CRR_CH1_RESULT_LOW, 1'b0, lo);
        check(lo, res[15:0]);
        i_host.rd_result(1, hi, lo);
        check(hi, 16'h0012);
        check(lo, 16'h3456);
        for (int c = 0; c < 4; c++)
        begin
            res = 28'h7E1C0D0 + 28'(c);
            convert(c, 4'hF, res);
            i_host.rd_result(c, hi, lo);
            check(hi, {4'hF, res[27:16]});
            check(lo, res[15:0]);
        end
        // A conversion offered while frozen must leave no trace
        clk_en = 1'b0;
        convert(2, 4'h3, 28'h0BADC0D);
        clk_en = 1'b1;
        i_host.rd_result(2, hi, lo);
        check(hi, 16'h07E1);
        check(lo, 16'hC0D2);
        i_host.wr(CRR_CH3_RESULT_LOW, 16'hFFFF);
        i_host.rd(CRR_CH3_RESULT_LOW, 1'b0, lo);
        check(lo, res[15:0]);
        i_host.rd(8'h09, 1'b0, hi);
        check({hi[15:1], unmapped_q}, 16'h0001);
        // Reserved setting first, then the smallest legal one
        for (int v = 3; v < 6; v += 2)
        begin
            i_host.wr(CRR_CH0_CONVERSION_INTERVAL, 16'(v));
            i_host.rd(CRR_CH0_CONVERSION_INTERVAL, 1'b0, hi);
            check(hi, 16'(v));
            wait_done(n);
            @(posedge core_clk);
            #1;
            wait_done(n);
            check(16'(n + 1), 16'h00A0);
        end
        finish_test();
    end
endmodule : test_conversion_result_regs

`default_nettype wire
